// >>> verilog/adaptive_step_pkg.sv
// Purpose: constants and types shared by the load-adaptive step block
// Assumes: 50 MHz ref_clk_i, step/direction inputs from an external pin domain
// Notes: diagnostic outputs are open drain (low active) or push-pull (high active)
// How it works
// - each diagnostic output selects a source and open-drain or push-pull type.
// - diag_out_zero pulls low while the device is held in reset.
// - stall asserts when load result is zero and step interval at or below threshold.
// - index pulses at microstep counter zero, lasting the whole microstep.
// - with interpolation below 256 microsteps the index may last two clocks.
// - chopper on-state alternates between both coils, only with constant off-time chopper.
// - skipped-step signal toggles for each commanded step not executed.
// - load-adaptive mode forces slow decay only; constant off-time chopper is set by chopper_const_off_i.
// - force-enable high selects load-adaptive mode; else velocity threshold may select it.
// - load-adaptive mode stays off while the quiet voltage chopper is active.
// - step-ready goes low while the previous step is not yet taken.
// - steps are buffered up to microsteps per fullstep minus one while waiting.
// - a step held for at least 1024 clocks forces one step past the wait.
// - in load-adaptive mode, step hold low stops execution and forces step-ready low.
// - each refused step moves the skipped-step counter by direction.
// - step input stays at microstep resolution while execution is fullstep based.
// - the device halts before the next fullstep if the last was not taken.
// - a blocked motor still steps at the minimum velocity; zero disables it.
// - a step advances the position with direction 0 and retreats with 1.
// - in load-adaptive mode stall appears as a pulse on a diagnostic output.
package adaptive_step_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned FORCE_PULSE_CLOCKS = 1024;
  localparam int unsigned FORCE_PULSE_US = 125;
  localparam int unsigned POS_W = 10;
  localparam int unsigned INTERVAL_W = 20;
  localparam int unsigned VDC_W = 22;
  localparam int unsigned LOST_W = 20;
  localparam int unsigned BUF_W = 9;
  localparam int unsigned FORCE_CNT_W = 11;
  localparam logic [POS_W-1:0] POS_RESET = 10'h000;
  localparam logic [LOST_W-1:0] LOST_RESET = 20'h00000;
  localparam logic [3:0] RES_FULL_CODE = 4'h8;

  typedef enum logic [2:0] {
    DIAG_SRC_STALL,
    DIAG_SRC_INDEX,
    DIAG_SRC_CHOP_ON,
    DIAG_SRC_SKIPPED,
    DIAG_SRC_RESET,
    DIAG_SRC_OFF
  } diag_src_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT_TAKEN,
    SEQ_FORCED
  } seq_state_type;

  // microsteps per fullstep for a resolution code (0 = 256, 8 = fullstep)
  function automatic logic [8:0] steps_per_full(input logic [3:0] res_code);
    steps_per_full = (res_code > RES_FULL_CODE) ? 9'h001 : 9'(9'h100 >> res_code);
  endfunction
endpackage

// >>> verilog/diag_pin_if.sv
`timescale 1ns/1ns
// Purpose: carries one diagnostic output's selection and event sources
// Assumes: single clock domain
// Notes: the driver modport produces the two pin signals
interface diag_pin_if;
  import adaptive_step_pkg::*;
  diag_src_type src;
  logic push_pull;
  logic in_reset;
  logic stall;
  logic index;
  logic chop_on;
  logic skipped;
  logic pin_out;
  logic pin_oe_n;
  modport source (output src, push_pull, in_reset, stall, index, chop_on, skipped, input pin_out, pin_oe_n);
  modport driver (input src, push_pull, in_reset, stall, index, chop_on, skipped, output pin_out, pin_oe_n);
endinterface

// >>> verilog/diag_pin_drive.sv
`timescale 1ns/1ns
// Purpose: drives one diagnostic pin from its selected source
// Assumes: sources are registered in the caller
// Notes: open drain enables the driver only when the signal is active
module diag_pin_drive
  import adaptive_step_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  diag_pin_if.driver diag
);
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_state_type;
  pin_state_type s_q;
  pin_state_type s_d;
  logic active;

  always_comb
  begin
    case (diag.src)
      DIAG_SRC_STALL: active = diag.stall;
      DIAG_SRC_INDEX: active = diag.index;
      DIAG_SRC_CHOP_ON: active = diag.chop_on;
      DIAG_SRC_SKIPPED: active = diag.skipped;
      DIAG_SRC_RESET: active = diag.in_reset;
      default: active = 1'b0;
    endcase
    if (diag.in_reset)
      active = 1'b1;
    s_d = s_q;
    if (diag.push_pull && !diag.in_reset)
    begin
      s_d.out = active;
      s_d.oe_n = 1'b0;
    end
    else
    begin
      s_d.out = 1'b0;
      s_d.oe_n = ~active;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q.out <= 1'b0;
      s_q.oe_n <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // reset pull-low must not wait for a clock edge
  assign diag.pin_out = s_q.out;
  assign diag.pin_oe_n = rst_n_i ? s_q.oe_n : 1'b0;
endmodule

// >>> verilog/load_adaptive_step_diag.sv
`timescale 1ns/1ns
// Purpose: load-adaptive fullstep sequencing behind a step/direction interface with diagnostics
// Assumes: motor_step_taken_i pulses when the mechanics completed the last fullstep
// Notes: step, direction and hold pins pass three-flop synchronisers
module load_adaptive_step_diag
  import adaptive_step_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic step_hold_in_n_i,
  input wire logic adaptive_force_enable_i,
  input wire logic [3:0] microstep_resolution_setting_i,
  input wire logic interpolation_enable_i,
  input wire logic quiet_chopper_enable_i,
  input wire logic [INTERVAL_W-1:0] quiet_mode_velocity_threshold_i,
  input wire logic [INTERVAL_W-1:0] load_velocity_threshold_i,
  input wire logic [VDC_W-1:0] adaptive_min_velocity_i,
  input wire logic [9:0] load_measure_result_i,
  input wire logic motor_step_taken_i,
  input wire logic chopper_const_off_i,
  input wire logic coil_a_on_i,
  input wire logic coil_b_on_i,
  input wire logic [2:0] diag_zero_select_i,
  input wire logic diag_zero_push_pull_i,
  input wire logic [2:0] diag_one_select_i,
  input wire logic diag_one_push_pull_i,
  output logic step_ready_out_o,
  output logic fullstep_pulse_o,
  output logic load_adaptive_mode_o,
  output logic chopper_slow_decay_only_o,
  output logic [POS_W-1:0] microstep_position_count_o,
  output logic [LOST_W-1:0] lost_step_count_o,
  output logic [INTERVAL_W-1:0] step_interval_time_o,
  output logic stall_o,
  output logic diag_out_zero_o,
  output logic diag_out_zero_oe_n_o,
  output logic diag_out_one_o,
  output logic diag_out_one_oe_n_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;

  typedef struct packed {
    logic [2:0] step_sync;
    logic [2:0] dir_sync;
    logic [2:0] hold_sync;
    logic step_lvl;
    logic dir_lvl;
    logic hold_n_lvl;
    seq_state_type state;
    logic [POS_W-1:0] pos;
    logic [BUF_W-1:0] pending;
    logic [LOST_W-1:0] lost;
    logic [INTERVAL_W-1:0] interval_cnt;
    logic [INTERVAL_W-1:0] interval;
    logic [FORCE_CNT_W-1:0] high_cnt;
    logic force_used;
    logic [VDC_W-1:0] vmin_cnt;
    logic fs_pulse;
    logic skipped;
    logic stall;
    logic stall_d1;
    logic index;
    logic chop_sel;
  } core_state_type;
  core_state_type s_q;
  core_state_type s_d;

  logic adaptive;
  logic step_edge;
  logic [8:0] per_full;
  logic [POS_W-1:0] step_width;
  logic fs_boundary;
  logic step_now;
  logic hold_active;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign per_full = steps_per_full(microstep_resolution_setting_i);
  assign step_width = POS_W'(per_full == 9'h001 ? 10'h100 : 10'h100 / per_full);
  assign hold_active = !s_q.hold_n_lvl;
  // quiet chopper below its switching velocity blocks the mode
  assign adaptive = (adaptive_force_enable_i
    || (!quiet_chopper_enable_i && s_q.interval != '0 && s_q.interval < quiet_mode_velocity_threshold_i))
    && !(quiet_chopper_enable_i && s_q.interval >= quiet_mode_velocity_threshold_i);

  always_comb
  begin
    s_d = s_q;
    s_d.step_sync = {s_q.step_sync[1:0], step_i};
    s_d.dir_sync = {s_q.dir_sync[1:0], dir_i};
    s_d.hold_sync = {s_q.hold_sync[1:0], step_hold_in_n_i};
    if (s_q.step_sync[2] == s_q.step_sync[1])
      s_d.step_lvl = s_q.step_sync[2];
    if (s_q.dir_sync[2] == s_q.dir_sync[1])
      s_d.dir_lvl = s_q.dir_sync[2];
    if (s_q.hold_sync[2] == s_q.hold_sync[1])
      s_d.hold_n_lvl = s_q.hold_sync[2];
    step_edge = s_d.step_lvl && !s_q.step_lvl;
    s_d.fs_pulse = 1'b0;
    step_now = 1'b0;
    fs_boundary = 1'b0;

    // step interval in clocks, edge cycle counts as the first, saturating
    if (step_edge)
    begin
      s_d.interval = s_q.interval_cnt;
      s_d.interval_cnt = INTERVAL_W'(1);
    end
    else if (s_q.interval_cnt != '1)
      s_d.interval_cnt = s_q.interval_cnt + 1'b1;

    // long high step counter for forcing
    if (!s_q.step_lvl)
    begin
      s_d.high_cnt = '0;
      s_d.force_used = 1'b0;
    end
    else if (s_q.high_cnt != FORCE_CNT_W'(FORCE_PULSE_CLOCKS))
      s_d.high_cnt = s_q.high_cnt + 1'b1;

    if (!adaptive)
    begin
      // plain microstep mode, each step moves the table directly
      s_d.state = SEQ_IDLE;
      s_d.pending = '0;
      if (step_edge)
        s_d.pos = s_d.dir_lvl ? s_q.pos - step_width : s_q.pos + step_width;
    end
    else
    begin
      // incoming steps accumulate at microstep resolution
      if (step_edge)
      begin
        if (s_q.pending < BUF_W'(per_full - 9'h001) || s_q.state == SEQ_IDLE)
          s_d.pending = s_q.pending + 1'b1;
        else
        begin
          s_d.skipped = ~s_q.skipped;
          s_d.lost = s_d.dir_lvl ? s_q.lost - 1'b1 : s_q.lost + 1'b1;
        end
      end
      fs_boundary = s_d.pending >= BUF_W'(per_full);
      case (s_q.state)
        SEQ_IDLE:
        begin
          if (fs_boundary && !hold_active)
            step_now = 1'b1;
        end
        SEQ_WAIT_TAKEN:
        begin
          if (motor_step_taken_i)
            s_d.state = SEQ_IDLE;
          else if (s_q.high_cnt == FORCE_CNT_W'(FORCE_PULSE_CLOCKS) && !s_q.force_used)
          begin
            s_d.force_used = 1'b1;
            s_d.state = SEQ_FORCED;
          end
          else if (adaptive_min_velocity_i != '0 && s_q.vmin_cnt >= adaptive_min_velocity_i)
            s_d.state = SEQ_FORCED;
          if (adaptive_min_velocity_i != '0 && s_q.vmin_cnt < adaptive_min_velocity_i)
            s_d.vmin_cnt = s_q.vmin_cnt + 1'b1;
        end
        SEQ_FORCED:
        begin
          s_d.state = SEQ_IDLE;
          if (!hold_active)
            step_now = 1'b1;
        end
        default: s_d.state = SEQ_IDLE;
      endcase
      if (step_now)
      begin
        // one fullstep executed, then wait for mechanics
        s_d.fs_pulse = 1'b1;
        s_d.pending = (s_d.pending >= BUF_W'(per_full)) ? s_d.pending - BUF_W'(per_full) : '0;
        s_d.pos = s_d.dir_lvl ? s_q.pos - POS_W'(10'h100) : s_q.pos + POS_W'(10'h100);
        s_d.state = SEQ_WAIT_TAKEN;
        s_d.vmin_cnt = '0;
      end
    end

    s_d.stall = (load_measure_result_i == '0) && (s_q.interval <= load_velocity_threshold_i);
    s_d.stall_d1 = s_q.stall;
    s_d.index = (s_d.pos == '0);
    if (coil_a_on_i ^ coil_b_on_i)
      s_d.chop_sel = coil_b_on_i;
    else
      s_d.chop_sel = ~s_q.chop_sel;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.hold_sync <= 3'b111;
      s_q.hold_n_lvl <= 1'b1;
      s_q.state <= SEQ_IDLE;
      s_q.pos <= POS_RESET;
      s_q.lost <= LOST_RESET;
    end
    else
      s_q <= s_d;
  end

  assign step_ready_out_o = !adaptive ? 1'b1
    : !(hold_active || s_q.state != SEQ_IDLE);
  assign fullstep_pulse_o = s_q.fs_pulse;
  assign load_adaptive_mode_o = adaptive;
  assign chopper_slow_decay_only_o = adaptive;
  assign microstep_position_count_o = s_q.pos;
  assign lost_step_count_o = s_q.lost;
  assign step_interval_time_o = s_q.interval;
  assign stall_o = s_q.stall;

  diag_pin_if diag_zero ();
  diag_pin_if diag_one ();
  logic stall_evt;
  logic chop_on;
  // stall reported as a rising pulse in adaptive mode, as a level otherwise
  assign stall_evt = adaptive ? (s_q.stall && !s_q.stall_d1) : s_q.stall;
  assign chop_on = chopper_const_off_i && (s_q.chop_sel ? coil_b_on_i : coil_a_on_i);

  assign diag_zero.src = diag_src_type'(diag_zero_select_i);
  assign diag_zero.push_pull = diag_zero_push_pull_i;
  assign diag_zero.in_reset = !rst_n;
  assign diag_zero.stall = stall_evt;
  assign diag_zero.index = s_q.index;
  assign diag_zero.chop_on = chop_on;
  assign diag_zero.skipped = s_q.skipped;
  assign diag_one.src = diag_src_type'(diag_one_select_i);
  assign diag_one.push_pull = diag_one_push_pull_i;
  assign diag_one.in_reset = 1'b0;
  assign diag_one.stall = stall_evt;
  assign diag_one.index = s_q.index;
  assign diag_one.chop_on = chop_on;
  assign diag_one.skipped = s_q.skipped;

  diag_pin_drive u_diag_zero (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .diag(diag_zero.driver)
  );
  diag_pin_drive u_diag_one (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .diag(diag_one.driver)
  );

  assign diag_out_zero_o = diag_zero.pin_out;
  assign diag_out_zero_oe_n_o = diag_zero.pin_oe_n;
  assign diag_out_one_o = diag_one.pin_out;
  assign diag_out_one_oe_n_o = diag_one.pin_oe_n;
endmodule

// >>> testbench/load_adaptive_step_diag_checker.sv
`timescale 1ns/1ns
// Purpose: port-level checks of the load-adaptive step block
// Assumes: one clock, direction held steady while steps are refused
// Notes: stall and skipped checks allow register latency of a few cycles
module load_adaptive_step_diag_checker
  import adaptive_step_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic step_hold_in_n_i,
  input wire logic adaptive_force_enable_i,
  input wire logic quiet_chopper_enable_i,
  input wire logic [INTERVAL_W-1:0] load_velocity_threshold_i,
  input wire logic [9:0] load_measure_result_i,
  input wire logic [2:0] diag_one_select_i,
  input wire logic diag_one_push_pull_i,
  input wire logic step_ready_out_o,
  input wire logic fullstep_pulse_o,
  input wire logic load_adaptive_mode_o,
  input wire logic chopper_slow_decay_only_o,
  input wire logic [LOST_W-1:0] lost_step_count_o,
  input wire logic [INTERVAL_W-1:0] step_interval_time_o,
  input wire logic stall_o,
  input wire logic diag_out_zero_o,
  input wire logic diag_out_zero_oe_n_o,
  input wire logic diag_out_one_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  AST_RST_LOW: assert property ($rose(arst_n_i) |-> !diag_out_zero_o && !diag_out_zero_oe_n_o)
    else $error("diag zero let go while reset still held");
  AST_OFF_READY: assert property (!load_adaptive_mode_o |-> step_ready_out_o)
    else $error("ready low with mode off");
  AST_HOLD_READY: assert property ((load_adaptive_mode_o && !step_hold_in_n_i) [*5] |-> !step_ready_out_o)
    else $error("ready high during hold");
  AST_FORCE_MODE: assert property (adaptive_force_enable_i && !quiet_chopper_enable_i |-> load_adaptive_mode_o)
    else $error("force enable ignored");
  AST_SLOW_DECAY: assert property (chopper_slow_decay_only_o == load_adaptive_mode_o)
    else $error("slow decay does not follow mode");
  AST_FULL_WAIT: assert property (load_adaptive_mode_o && fullstep_pulse_o |-> !step_ready_out_o)
    else $error("ready high at fullstep");
  AST_FULL_ONCE: assert property (fullstep_pulse_o |=> !fullstep_pulse_o)
    else $error("fullstep pulse longer than one cycle");
  AST_STALL: assert property (
    (load_measure_result_i == 10'h000 && step_interval_time_o <= load_velocity_threshold_i) [*2] |-> stall_o)
    else $error("stall missing");
  AST_LOST_ONE: assert property (
    $changed(lost_step_count_o) |-> lost_step_count_o - $past(lost_step_count_o) inside {20'h00001, 20'hFFFFF})
    else $error("lost count moved by more than one");
  AST_SKIP_TOGGLE: assert property (
    diag_one_select_i == 3'h3 && diag_one_push_pull_i && $changed(lost_step_count_o) |-> ##[0:2] $changed(diag_out_one_o))
    else $error("skipped output did not toggle");
  cover property (load_adaptive_mode_o && fullstep_pulse_o);
  cover property ($changed(lost_step_count_o));
  cover property ($rose(stall_o));
endmodule
bind load_adaptive_step_diag load_adaptive_step_diag_checker chk (.ref_clk_i, .arst_n_i, .step_hold_in_n_i,
  .adaptive_force_enable_i, .quiet_chopper_enable_i, .load_velocity_threshold_i, .load_measure_result_i,
  .diag_one_select_i, .diag_one_push_pull_i, .step_ready_out_o, .fullstep_pulse_o, .load_adaptive_mode_o,
  .chopper_slow_decay_only_o, .lost_step_count_o, .step_interval_time_o, .stall_o, .diag_out_zero_o,
  .diag_out_zero_oe_n_o, .diag_out_one_o);

// >>> testbench/step_controller_model.sv
`timescale 1ns/1ns
// Purpose: motion controller issuing step and direction pulses
// Assumes: pins change 2 ns after a clock edge
// Notes: obey clear models a controller that cannot react to step ready
module step_controller_model
(
  input wire logic clk_i,
  input wire logic ready_i,
  output logic step_o,
  output logic dir_o
);
  logic obey = 1'b1;
  initial
  begin
    step_o = 1'b0;
    dir_o = 1'b0;
  end
  task automatic pulses(input int n, input int w, input logic dir);
    dir_o = dir;
    repeat (n)
    begin
      while (obey && !ready_i)
      begin
        @(posedge clk_i);
        #2;
      end
      step_o = 1'b1;
      repeat (w) @(posedge clk_i);
      #2;
      step_o = 1'b0;
      repeat (w) @(posedge clk_i);
      #2;
    end
  endtask
endmodule

// >>> testbench/load_adaptive_step_diag_tb.sv
`timescale 1ns/1ns
// Purpose: self-checking bench for the load-adaptive step block
// Assumes: motor model answers taken one cycle after ready drops
// Notes: forcing pulse is kept short of the recommended length to save run time
module load_adaptive_step_diag_tb;
  import adaptive_step_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic step_hold_in_n_i = 1'b1;
  logic adaptive_force_enable_i = 1'b0;
  logic quiet_chopper_enable_i = 1'b1;
  logic motor_step_taken_i = 1'b0;
  logic chopper_const_off_i = 1'b1;
  logic coil_a_on_i = 1'b0;
  logic coil_b_on_i = 1'b0;
  logic diag_zero_push_pull_i = 1'b1;
  logic diag_one_push_pull_i = 1'b1;
  logic [3:0] microstep_resolution_setting_i = 4'h8;
  logic [2:0] diag_zero_select_i = 3'h0;
  logic [2:0] diag_one_select_i = 3'h1;
  logic [VDC_W-1:0] adaptive_min_velocity_i = '0;
  logic [9:0] load_measure_result_i = 10'h3FF;
  logic step_i, dir_i, step_ready_out_o, fullstep_pulse_o, load_adaptive_mode_o, chopper_slow_decay_only_o;
  logic stall_o, diag_out_zero_o, diag_out_zero_oe_n_o, diag_out_one_o, diag_out_one_oe_n_o, was;
  logic [POS_W-1:0] microstep_position_count_o;
  logic [INTERVAL_W-1:0] step_interval_time_o;
  logic [LOST_W-1:0] lost_step_count_o;
  logic motor_ok = 1'b0;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int fs_cnt = 0;
  int n;
  load_adaptive_step_diag dut (.ref_clk_i, .arst_n_i, .step_i, .dir_i, .step_hold_in_n_i, .adaptive_force_enable_i,
    .microstep_resolution_setting_i, .interpolation_enable_i(1'b0), .quiet_chopper_enable_i,
    .quiet_mode_velocity_threshold_i(20'h00000), .load_velocity_threshold_i(20'hFFFFF), .adaptive_min_velocity_i,
    .load_measure_result_i, .motor_step_taken_i, .chopper_const_off_i, .coil_a_on_i, .coil_b_on_i,
    .diag_zero_select_i, .diag_zero_push_pull_i, .diag_one_select_i, .diag_one_push_pull_i, .step_ready_out_o,
    .fullstep_pulse_o, .load_adaptive_mode_o, .chopper_slow_decay_only_o, .microstep_position_count_o,
    .lost_step_count_o, .step_interval_time_o, .stall_o, .diag_out_zero_o, .diag_out_zero_oe_n_o,
    .diag_out_one_o, .diag_out_one_oe_n_o);
  step_controller_model ctl (.clk_i(ref_clk_i), .ready_i(step_ready_out_o), .step_o(step_i), .dir_o(dir_i));
  always #10 ref_clk_i = ~ref_clk_i;
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #2;
  endtask
  // the motor answers only when allowed, so a blocked motor is one flag
  always @(posedge ref_clk_i)
  begin
    motor_step_taken_i <= #2 motor_ok && !step_ready_out_o;
    cycles++;
    if (fullstep_pulse_o === 1'b1)
      fs_cnt++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  initial
  begin
    tick(12);
    arst_n_i = 1'b1;
    tick(4);
    ctl.pulses(3, 4, 1'b0);
    tick(4);
    check(load_adaptive_mode_o, 1'b0);
    check(step_ready_out_o, 1'b1);
    check(microstep_position_count_o, 10'h300);
    check(step_interval_time_o, 20'h00008);
    check(diag_out_one_o, 1'b0);
    check(diag_out_one_oe_n_o, 1'b0);
    ctl.pulses(1, 4, 1'b0);
    tick(4);
    check(diag_out_one_o, 1'b1);
    ctl.pulses(1, 4, 1'b1);
    tick(4);
    check(microstep_position_count_o, 10'h300);
    $display("test plain stepping done");
    adaptive_force_enable_i = 1'b1;
    quiet_chopper_enable_i = 1'b0;
    motor_ok = 1'b1;
    microstep_resolution_setting_i = 4'h6;
    tick(4);
    check(load_adaptive_mode_o, 1'b1);
    check(chopper_slow_decay_only_o, 1'b1);
    n = fs_cnt;
    ctl.pulses(8, 4, 1'b0);
    tick(20);
    check(fs_cnt - n, 2);
    check(lost_step_count_o, 20'h00000);
    step_hold_in_n_i = 1'b0;
    tick(6);
    check(step_ready_out_o, 1'b0);
    step_hold_in_n_i = 1'b1;
    tick(6);
    check(step_ready_out_o, 1'b1);
    $display("test adaptive handshake done");
    motor_ok = 1'b0;
    ctl.obey = 1'b0;
    diag_one_select_i = 3'h3;
    tick(2);
    n = fs_cnt;
    ctl.pulses(9, 4, 1'b0);
    tick(8);
    check(step_ready_out_o, 1'b0);
    check(fs_cnt - n, 1);
    check(lost_step_count_o, 20'h00002);
    was = diag_out_one_o;
    ctl.pulses(1, 4, 1'b1);
    tick(8);
    check(lost_step_count_o, 20'h00001);
    check(diag_out_one_o, !was);
    load_measure_result_i = 10'h000;
    tick(4);
    check(stall_o, 1'b1);
    load_measure_result_i = 10'h3FF;
    $display("test overload done");
    n = fs_cnt;
    ctl.pulses(1, 1030, 1'b0);
    tick(8);
    check(fs_cnt - n, 1);
    adaptive_min_velocity_i = 22'h00012C;
    n = fs_cnt;
    tick(400);
    check(fs_cnt > n, 1'b1);
    adaptive_min_velocity_i = '0;
    tick(4);
    n = fs_cnt;
    tick(400);
    check(fs_cnt - n, 0);
    $display("test forcing done");
    diag_zero_select_i = 3'h2;
    for (int k = 0; k < 4; k++)
    begin
      diag_zero_push_pull_i = k[1];
      coil_a_on_i = k[0];
      coil_b_on_i = k[0];
      tick(4);
      check({diag_out_zero_o, diag_out_zero_oe_n_o}, k[1] ? {k[0], 1'b0} : {1'b0, !k[0]});
    end
    arst_n_i = 1'b0;
    tick(2);
    check({diag_out_zero_o, diag_out_zero_oe_n_o}, 2'h0);
    arst_n_i = 1'b1;
    tick(4);
    $display("test diagnostics done");
    conclude();
  end
endmodule
